// *** hw/mfr_coil_bank.sv ***
// Coil outputs with per-coil force and release
`timescale 1ns/1ns
`default_nettype none
module mfr_coil_bank (
    input  wire logic                          sys_clk,   // System clock
    input  wire logic                          reset,     // Sync reset, high
    input  wire mfr_pkg::mfr_coil_wr_t         wr,        // Force request
    input  wire logic [mfr_pkg::NUM_COILS-1:0] coil_auto, // Application drive
    output logic [mfr_pkg::NUM_COILS-1:0]      coil_out   // Coil state
);
    logic [mfr_pkg::NUM_COILS-1:0] force_en;
    logic [mfr_pkg::NUM_COILS-1:0] force_val;
    logic [mfr_pkg::NUM_COILS-1:0] next_force_en;
    logic [mfr_pkg::NUM_COILS-1:0] next_force_val;

    // ======================================================
    // Force state
    always_comb begin
        next_force_en  = (force_en & ~wr.mask) | (wr.release_f ? '0 : wr.mask);
        next_force_val = (force_val & ~wr.mask) | (wr.value & wr.mask);
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            force_en  <= '0;
            force_val <= '0;
        end else begin
            force_en  <= next_force_en;
            force_val <= next_force_val;
        end
    end

    assign coil_out = (force_en & force_val) | (~force_en & coil_auto);
endmodule : mfr_coil_bank
`default_nettype wire

// *** hw/mfr_responder.sv ***
// Function-code interpreter: takes a command body, answers it
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Code 01 returns coil states packed as bits.
// - Code 02 returns discrete input states packed as bits.
// - Read answer: station, code, byte count, then data bytes.
// - First requested bit sits in bit 0, later ones above it.
// - Codes 03 and 04 share request and answer layout.
// - Returned registers are 16 bits, high byte first.
// - Force value FF00 on, 0000 off, FFFF release; after coil address.
// - Code 05 answers with an echo after forcing.
// - Code 06 writes one register from address and data.
// - Code 06 answers with an echo after storing.
// - Code 08 echoes station, code and all data bytes.
// - Codes 15 and 16 write several coils or registers.
// - A six-byte head wraps each body; it is removed upstream.
// - Silent while idle; answers only a complete request.
module mfr_responder (
    input  wire logic                             sys_clk,     // System clock
    input  wire logic                             reset,       // Sync reset, high
    input  wire logic [7:0]                       station_id,  // Own station address
    input  wire logic                             rx_valid,    // Request byte valid
    input  wire mfr_pkg::mfr_byte_t               rx_byte,     // Request byte, last flag
    output logic                                  rx_ready,    // Request byte taken
    output logic                                  tx_valid,    // Answer byte valid
    output mfr_pkg::mfr_byte_t                    tx_byte,     // Answer byte, last flag
    input  wire logic                             tx_ready,    // Answer byte taken
    input  wire logic [mfr_pkg::NUM_INPUTS-1:0]   discrete_in, // Discrete inputs
    input  wire logic [mfr_pkg::NUM_REGS*16-1:0]  in_regs,     // Input registers
    input  wire logic [mfr_pkg::NUM_COILS-1:0]    coil_auto,   // Coil drive
    output logic [mfr_pkg::NUM_COILS-1:0]         coil_out,    // Coil state
    output logic [mfr_pkg::NUM_REGS*16-1:0]       hold_image   // Holding registers
);
    localparam int BUFW = mfr_pkg::BUF_BYTES * 8;

    mfr_pkg::mfr_state_t   state, next_state;
    mfr_pkg::mfr_kind_t    r_kind, next_kind, d_kind;
    mfr_pkg::mfr_coil_wr_t coil_wr;
    logic [BUFW-1:0]       rx_img;
    logic [7:0]            rx_len, r_len, next_len, d_len, r_exc, next_exc, d_exc;
    logic [7:0]            tx_idx, next_idx, next_tx_data;
    logic                  rx_ovf, rx_fire, buf_clear, d_drop, next_tx_valid, next_tx_last;
    logic [7:0]            f_station, f_func, f_bcnt;
    logic [15:0]           f_addr, f_cnt;
    logic [15:0]           hold [mfr_pkg::NUM_REGS];
    logic [15:0]           next_hold [mfr_pkg::NUM_REGS];

    // ======================================================
    // Helpers
    function automatic logic [7:0] img_byte(input int i);
        return (i < mfr_pkg::BUF_BYTES) ? rx_img[i*8 +: 8] : 8'h00;
    endfunction : img_byte
    function automatic logic fits(input logic [15:0] a, input logic [15:0] n,
                                  input int lim);
        return (n != 16'h0000) && (int'(a) + int'(n) <= lim);
    endfunction : fits
    function automatic logic [7:0] bit_bytes(input logic [15:0] n);
        return 8'((int'(n) + 7) / 8);
    endfunction : bit_bytes
    function automatic logic [7:0] resp_byte(input logic [7:0] idx);
        int         n;
        int         w;
        logic [15:0] word;
        logic [15:0] src;
        resp_byte = 8'h00;
        word      = 16'h0000;
        src       = (f_func == mfr_pkg::FC_RD_COIL) ? coil_out : discrete_in;
        if (r_kind == mfr_pkg::K_ECHO) begin
            resp_byte = img_byte(int'(idx));
        end else if (idx == 8'h00) begin
            resp_byte = f_station;
        end else if (idx == 8'h01) begin
            resp_byte = (r_kind == mfr_pkg::K_EXC) ? (f_func | mfr_pkg::EXC_FLAG)
                                                   : f_func;
        end else if (idx == 8'h02) begin
            resp_byte = (r_kind == mfr_pkg::K_EXC) ? r_exc : r_len - 8'h03;
        end else if (r_kind == mfr_pkg::K_BITS) begin
            for (int j = 0; j < 8; j++) begin
                n = (int'(idx) - mfr_pkg::POS_RDATA) * 8 + j;
                if (n < int'(f_cnt)) begin
                    resp_byte[j] = src[(int'(f_addr) + n) % 16];
                end
            end
        end else begin
            w = int'(f_addr) + (int'(idx) - mfr_pkg::POS_RDATA) / 2;
            word = (f_func == mfr_pkg::FC_RD_HOLD) ? hold[w % mfr_pkg::NUM_REGS]
                                                   : in_regs[(w % mfr_pkg::NUM_REGS)*16 +: 16];
            resp_byte = idx[0] ? word[15:8] : word[7:0];
        end
    endfunction : resp_byte

    // ======================================================
    // Request store
    assign rx_ready  = (state == mfr_pkg::ST_IDLE) || (state == mfr_pkg::ST_RECV);
    assign rx_fire   = rx_valid && rx_ready;
    assign buf_clear = (next_state == mfr_pkg::ST_IDLE) && (state != mfr_pkg::ST_IDLE);

    mfr_rx_buffer u_rx_buffer (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .clear    (buf_clear),
        .wr       (rx_fire),
        .wr_byte  (rx_byte),
        .image    (rx_img),
        .length   (rx_len),
        .overflow (rx_ovf)
    );
    mfr_coil_bank u_coil_bank (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .wr        (coil_wr),
        .coil_auto (coil_auto),
        .coil_out  (coil_out)
    );

    // ======================================================
    // Request decode and checks
    always_comb begin
        f_station = img_byte(mfr_pkg::POS_STATION);
        f_func    = img_byte(mfr_pkg::POS_FUNC);
        f_addr    = {img_byte(mfr_pkg::POS_ADDR), img_byte(mfr_pkg::POS_ADDR + 1)};
        f_cnt     = {img_byte(mfr_pkg::POS_CNT), img_byte(mfr_pkg::POS_CNT + 1)};
        f_bcnt    = img_byte(mfr_pkg::POS_BCNT);
        d_kind    = mfr_pkg::K_EXC;
        d_exc     = mfr_pkg::EXC_FUNC;
        d_len     = 8'(mfr_pkg::EXC_LEN);
        d_drop    = (rx_len < 8'h02) || rx_ovf || (f_station != station_id);
        case (f_func)
            mfr_pkg::FC_RD_COIL, mfr_pkg::FC_RD_INPUT: begin
                d_drop = d_drop || (int'(rx_len) != mfr_pkg::FIX_LEN);
                if (fits(f_addr, f_cnt, mfr_pkg::NUM_COILS)) begin
                    d_kind = mfr_pkg::K_BITS;
                    d_len  = 8'(mfr_pkg::POS_RDATA) + bit_bytes(f_cnt);
                end else begin
                    d_exc = mfr_pkg::EXC_ADDR;
                end
            end
            mfr_pkg::FC_RD_HOLD, mfr_pkg::FC_RD_INREG: begin
                d_drop = d_drop || (int'(rx_len) != mfr_pkg::FIX_LEN);
                if (fits(f_addr, f_cnt, mfr_pkg::NUM_REGS)) begin
                    d_kind = mfr_pkg::K_REGS;
                    d_len  = 8'(mfr_pkg::POS_RDATA) + 8'(f_cnt) + 8'(f_cnt);
                end else begin
                    d_exc = mfr_pkg::EXC_ADDR;
                end
            end
            mfr_pkg::FC_WR_COIL: begin
                d_drop = d_drop || (int'(rx_len) != mfr_pkg::FIX_LEN);
                if (!fits(f_addr, 16'h0001, mfr_pkg::NUM_COILS)) begin
                    d_exc = mfr_pkg::EXC_ADDR;
                end else if (f_cnt == mfr_pkg::FORCE_ON || f_cnt == mfr_pkg::FORCE_OFF
                             || f_cnt == mfr_pkg::FORCE_REL) begin
                    d_kind = mfr_pkg::K_ECHO;
                    d_len  = rx_len;
                end else begin
                    d_exc = mfr_pkg::EXC_VALUE;
                end
            end
            mfr_pkg::FC_WR_REG: begin
                d_drop = d_drop || (int'(rx_len) != mfr_pkg::FIX_LEN);
                if (fits(f_addr, 16'h0001, mfr_pkg::NUM_REGS)) begin
                    d_kind = mfr_pkg::K_ECHO;
                    d_len  = rx_len;
                end else begin
                    d_exc = mfr_pkg::EXC_ADDR;
                end
            end
            mfr_pkg::FC_LOOP: begin
                d_kind = mfr_pkg::K_ECHO;
                d_len  = rx_len;
            end
            mfr_pkg::FC_WR_COILS, mfr_pkg::FC_WR_REGS: begin
                d_drop = d_drop || (int'(rx_len) != mfr_pkg::POS_WDATA + int'(f_bcnt));
                if (!fits(f_addr, f_cnt, (f_func == mfr_pkg::FC_WR_COILS)
                          ? mfr_pkg::NUM_COILS : mfr_pkg::NUM_REGS)) begin
                    d_exc = mfr_pkg::EXC_ADDR;
                end else if (f_bcnt != ((f_func == mfr_pkg::FC_WR_COILS)
                             ? bit_bytes(f_cnt) : 8'(f_cnt) + 8'(f_cnt))) begin
                    d_exc = mfr_pkg::EXC_VALUE;
                end else begin
                    d_kind = mfr_pkg::K_ECHO;
                    d_len  = 8'(mfr_pkg::FIX_LEN);
                end
            end
            default: ;
        endcase
    end

    // ======================================================
    // Writes carried out in the execute cycle
    always_comb begin
        logic go;
        int   k;
        go      = (state == mfr_pkg::ST_EXEC) && !d_drop && (d_kind == mfr_pkg::K_ECHO);
        k       = 0;
        coil_wr = '0;
        for (int r = 0; r < mfr_pkg::NUM_REGS; r++) begin
            next_hold[r]           = hold[r];
            hold_image[r*16 +: 16] = hold[r];
        end
        if (go && f_func == mfr_pkg::FC_WR_COIL) begin
            coil_wr.mask[f_addr[3:0]]  = 1'b1;
            coil_wr.value[f_addr[3:0]] = (f_cnt == mfr_pkg::FORCE_ON);
            coil_wr.release_f          = (f_cnt == mfr_pkg::FORCE_REL);
        end
        if (go && f_func == mfr_pkg::FC_WR_REG) begin
            next_hold[f_addr[3:0]] = f_cnt;
        end
        for (int i = 0; i < mfr_pkg::NUM_REGS; i++) begin
            k = i - int'(f_addr);
            if (go && k >= 0 && k < int'(f_cnt)) begin
                if (f_func == mfr_pkg::FC_WR_COILS) begin
                    coil_wr.mask[i]  = 1'b1;
                    coil_wr.value[i] = rx_img[(mfr_pkg::POS_WDATA + k / 8) * 8 + k % 8];
                end else if (f_func == mfr_pkg::FC_WR_REGS) begin
                    next_hold[i] = {img_byte(mfr_pkg::POS_WDATA + 2 * k),
                                    img_byte(mfr_pkg::POS_WDATA + 2 * k + 1)};
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < mfr_pkg::NUM_REGS; i++) begin
            hold[i] <= reset ? mfr_pkg::HOLD_RESET : next_hold[i];
        end
    end

    // ======================================================
    // Sequencer and answer stream
    always_comb begin
        next_state    = state;
        next_kind     = r_kind;
        next_len      = r_len;
        next_exc      = r_exc;
        next_idx      = tx_idx;
        next_tx_valid = tx_valid;
        next_tx_data  = tx_byte.data;
        next_tx_last  = tx_byte.last;
        unique case (state)
            mfr_pkg::ST_IDLE, mfr_pkg::ST_RECV: begin
                if (rx_fire) begin
                    next_state = rx_byte.last ? mfr_pkg::ST_EXEC : mfr_pkg::ST_RECV;
                end
            end
            mfr_pkg::ST_EXEC: begin
                next_kind  = d_kind;
                next_len   = d_len;
                next_exc   = d_exc;
                next_idx   = 8'h00;
                next_state = d_drop ? mfr_pkg::ST_IDLE : mfr_pkg::ST_SEND;
                if (!d_drop) begin
                    next_tx_valid = 1'b1;
                    next_tx_data  = f_station;
                    next_tx_last  = (d_len == 8'h01);
                end
            end
            mfr_pkg::ST_SEND: begin
                if (tx_ready) begin
                    if (tx_byte.last) begin
                        next_state    = mfr_pkg::ST_IDLE;
                        next_tx_valid = 1'b0;
                        next_tx_last  = 1'b0;
                    end else begin
                        next_idx     = tx_idx + 8'h01;
                        next_tx_data = resp_byte(tx_idx + 8'h01);
                        next_tx_last = (tx_idx + 8'h02 == r_len);
                    end
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state    <= mfr_pkg::ST_IDLE;
            r_kind   <= mfr_pkg::K_EXC;
            r_len    <= 8'h00;
            r_exc    <= 8'h00;
            tx_idx   <= 8'h00;
            tx_valid <= 1'b0;
            tx_byte  <= '0;
        end else begin
            state        <= next_state;
            r_kind       <= next_kind;
            r_len        <= next_len;
            r_exc        <= next_exc;
            tx_idx       <= next_idx;
            tx_valid     <= next_tx_valid;
            tx_byte.data <= next_tx_data;
            tx_byte.last <= next_tx_last;
        end
    end

    // ======================================================
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence s_bad_func;
        state == mfr_pkg::ST_EXEC && !d_drop && d_exc == mfr_pkg::EXC_FUNC
            && d_kind == mfr_pkg::K_EXC;
    endsequence
    sequence s_exc_head;
        tx_valid && tx_byte.data == station_id && r_kind == mfr_pkg::K_EXC;
    endsequence
    a_idle_silent: assert property (state == mfr_pkg::ST_IDLE |-> !tx_valid)
        else $error("answer byte while idle");
    a_rx_closed: assert property (state == mfr_pkg::ST_SEND |-> !rx_ready)
        else $error("request taken while answering");
    a_wrong_station: assert property (state == mfr_pkg::ST_EXEC && f_station != station_id
        |=> state == mfr_pkg::ST_IDLE && !tx_valid)
        else $error("foreign station answered");
    a_exc_answer: assert property (s_bad_func |=> s_exc_head ##0 r_len == 8'h03)
        else $error("unsupported code not answered as exception");
    a_echo_bytes: assert property (state == mfr_pkg::ST_SEND && r_kind == mfr_pkg::K_ECHO
        |-> tx_byte.data == img_byte(int'(tx_idx)))
        else $error("echo byte differs from request");
    a_byte_count: assert property (state == mfr_pkg::ST_SEND && tx_idx == 8'h02
        && (r_kind == mfr_pkg::K_BITS || r_kind == mfr_pkg::K_REGS)
        |-> tx_byte.data == ((r_kind == mfr_pkg::K_REGS) ? 8'(f_cnt) + 8'(f_cnt)
                                                         : bit_bytes(f_cnt)))
        else $error("byte count wrong");
    a_last_flag: assert property (tx_valid && tx_idx + 8'h01 == r_len |-> tx_byte.last)
        else $error("last flag missing");
    a_force_on: assert property (state == mfr_pkg::ST_EXEC && !d_drop
        && f_func == mfr_pkg::FC_WR_COIL && d_kind == mfr_pkg::K_ECHO
        && f_cnt == mfr_pkg::FORCE_ON |=> coil_out[$past(f_addr[3:0])])
        else $error("coil not forced on");
    a_hold_write: assert property (state == mfr_pkg::ST_EXEC && !d_drop
        && f_func == mfr_pkg::FC_WR_REG && d_kind == mfr_pkg::K_ECHO
        |=> hold[$past(f_addr[3:0])] == $past(f_cnt))
        else $error("register not written");
endmodule : mfr_responder
`default_nettype wire

// *** hw/mfr_rx_buffer.sv ***
// Request byte store for one command body
`timescale 1ns/1ns
`default_nettype none
module mfr_rx_buffer (
    input  wire logic                            sys_clk,  // System clock
    input  wire logic                            reset,    // Sync reset, high
    input  wire logic                            clear,    // Empty the store
    input  wire logic                            wr,       // Byte accepted
    input  wire mfr_pkg::mfr_byte_t              wr_byte,  // Byte to store
    output logic [mfr_pkg::BUF_BYTES*8-1:0]      image,    // Stored bytes
    output logic [7:0]                           length,   // Bytes stored
    output logic                                 overflow  // Too many bytes
);
    logic [7:0] mem [mfr_pkg::BUF_BYTES];
    logic [7:0] next_length;
    logic       next_overflow;

    // ======================================================
    // Count and overflow
    always_comb begin
        next_length   = length;
        next_overflow = overflow;
        if (clear) begin
            next_length   = 8'h00;
            next_overflow = 1'b0;
        end else if (wr) begin
            if (int'(length) < mfr_pkg::BUF_BYTES) begin
                next_length = length + 8'h01;
            end else begin
                next_overflow = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            length   <= 8'h00;
            overflow <= 1'b0;
        end else begin
            length   <= next_length;
            overflow <= next_overflow;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (wr && !clear && int'(length) < mfr_pkg::BUF_BYTES) begin
            mem[length[5:0]] <= wr_byte.data;
        end
    end

    always_comb begin
        for (int i = 0; i < mfr_pkg::BUF_BYTES; i++) begin
            image[i*8 +: 8] = mem[i];
        end
    end
endmodule : mfr_rx_buffer
`default_nettype wire

// *** include/mfr_pkg.sv ***
// Package of constants and types for the function-code responder
package mfr_pkg;

    // ======================================================
    // Sizes
    localparam int BUF_BYTES  = 64;
    localparam int NUM_COILS  = 16;
    localparam int NUM_INPUTS = 16;
    localparam int NUM_REGS   = 16;
    localparam int LOOP_MAX   = BUF_BYTES / 2 - 8;

    // ======================================================
    // Function codes and exception codes
    localparam logic [7:0] FC_RD_COIL  = 8'h01;
    localparam logic [7:0] FC_RD_INPUT = 8'h02;
    localparam logic [7:0] FC_RD_HOLD  = 8'h03;
    localparam logic [7:0] FC_RD_INREG = 8'h04;
    localparam logic [7:0] FC_WR_COIL  = 8'h05;
    localparam logic [7:0] FC_WR_REG   = 8'h06;
    localparam logic [7:0] FC_LOOP     = 8'h08;
    localparam logic [7:0] FC_WR_COILS = 8'h0f;
    localparam logic [7:0] FC_WR_REGS  = 8'h10;
    localparam logic [7:0] EXC_FLAG    = 8'h80;
    localparam logic [7:0] EXC_FUNC    = 8'h01;
    localparam logic [7:0] EXC_ADDR    = 8'h02;
    localparam logic [7:0] EXC_VALUE   = 8'h03;

    // ======================================================
    // Force values for a single coil
    localparam logic [15:0] FORCE_ON  = 16'hff00;
    localparam logic [15:0] FORCE_OFF = 16'h0000;
    localparam logic [15:0] FORCE_REL = 16'hffff;

    // ======================================================
    // Byte positions in a command body
    localparam int POS_STATION = 0;
    localparam int POS_FUNC    = 1;
    localparam int POS_ADDR    = 2;
    localparam int POS_CNT     = 4;
    localparam int POS_BCNT    = 6;
    localparam int POS_WDATA   = 7;
    localparam int POS_RDATA   = 3;
    localparam int FIX_LEN     = 6;
    localparam int EXC_LEN     = 3;
    localparam logic [15:0] HOLD_RESET = 16'h0000;

    // ======================================================
    // Types
    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } mfr_byte_t;

    typedef struct packed {
        logic [NUM_COILS-1:0] mask;
        logic [NUM_COILS-1:0] value;
        logic                 release_f;
    } mfr_coil_wr_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RECV = 2'b01,
        ST_EXEC = 2'b11,
        ST_SEND = 2'b10
    } mfr_state_t;

    typedef enum logic [1:0] {
        K_ECHO, K_EXC, K_BITS, K_REGS
    } mfr_kind_t;

endpackage : mfr_pkg

// *** verif/mfr_host.sv ***
// Host model: sends one command body and collects the answer
`timescale 1ns/1ns
`default_nettype none
module mfr_host (
    input  wire logic               sys_clk,  // System clock
    output mfr_pkg::mfr_byte_t      rx_byte,  // Request byte
    output logic                    rx_valid, // Request byte valid
    input  wire logic               rx_ready, // Request byte taken
    input  wire mfr_pkg::mfr_byte_t tx_byte,  // Answer byte
    input  wire logic               tx_valid, // Answer byte valid
    output logic                    tx_ready  // Answer byte taken
);
    int hung = 0;
    initial begin
        rx_valid = 1'b0;
        rx_byte  = '0;
        tx_ready = 1'b0;
    end
    task automatic xfer(input logic [7:0] req[$], input bit slow, output logic [7:0] rsp[$]);
        int n;
        logic take;
        mfr_pkg::mfr_byte_t b;
        rsp = {};
        foreach (req[i]) begin
            rx_valid = 1'b1;
            rx_byte = {req[i], i == req.size() - 1};
            n = 0;
            while (rx_ready !== 1'b1 && n < 50) begin
                @(posedge sys_clk);
                #1 n++;
            end
            if (n >= 50) hung++;
            @(posedge sys_clk);
            #1;
        end
        rx_valid = 1'b0;
        rx_byte = {~rx_byte.data, 1'b0};
        n = 0;
        while (n < 300) begin
            tx_ready = !slow || n[0];
            take = tx_valid === 1'b1 && tx_ready;
            b = tx_byte;
            @(posedge sys_clk);
            #1 n++;
            if (take) rsp.push_back(b.data);
            if (take && b.last === 1'b1) n = 1000;
        end
        tx_ready = 1'b0;
    endtask : xfer
endmodule : mfr_host
`default_nettype wire

// *** verif/tb_modbus_function_responder.sv ***
// Bench for the function-code responder
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_modbus_function_responder;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic rx_valid, rx_ready, tx_valid, tx_ready;
    mfr_pkg::mfr_byte_t rx_byte, tx_byte;
    logic [15:0] discrete_in = 16'ha5c3;
    logic [15:0] coil_auto = 16'h0042;
    logic [15:0] coil_out;
    logic [255:0] in_regs, hold_image;
    int error_cnt = 0;
    int n_compared = 0;
    always #5 sys_clk = ~sys_clk;
    mfr_responder dut (.sys_clk, .reset, .station_id(8'h11), .rx_valid, .rx_byte, .rx_ready,
        .tx_valid, .tx_byte, .tx_ready, .discrete_in, .in_regs, .coil_auto, .coil_out, .hold_image);
    mfr_host host (.sys_clk, .rx_byte, .rx_valid, .rx_ready, .tx_byte, .tx_valid, .tx_ready);
    // ==========================================
    // One request, answer compared as a whole
    task automatic run(input int nq, input logic [127:0] q, input int na,
                       input logic [127:0] a, input bit slow);
        logic [7:0] req[$];
        logic [7:0] rsp[$];
        logic [127:0] got;
        got = '0;
        for (int i = nq - 1; i >= 0; i--) req.push_back(q[i*8+:8]);
        host.xfer(req, slow, rsp);
        foreach (rsp[i]) got = {got[119:0], rsp[i]};
        `CHK("length", na, rsp.size())
        `CHK("answer", a, got)
    endtask : run
    task automatic t_bits();
        run(6, 128'h110100000008, 4, 128'h11010142, 0);
        run(6, 128'h110100010003, 4, 128'h11010101, 0);
        run(6, 128'h110200070009, 5, 128'({24'h110202, discrete_in[14:7], 7'h0, discrete_in[15]}), 0);
        run(6, 128'h1101000f0002, 3, 128'h118102, 0);
    endtask : t_bits
    task automatic t_coil();
        run(6, 128'h11050003ff00, 6, 128'h11050003ff00, 0);
        run(6, 128'h110500010000, 6, 128'h110500010000, 1);
        `CHK("coil_out", 16'h0048, coil_out)
        run(6, 128'h11050003ffff, 6, 128'h11050003ffff, 0);
        `CHK("coil_out", 16'h0040, coil_out)
        run(6, 128'h110100000008, 4, 128'h11010140, 0);
        run(6, 128'h110500031234, 3, 128'h118503, 0);
    endtask : t_coil
    task automatic t_regs();
        run(6, 128'h11060005beef, 6, 128'h11060005beef, 0);
        `CHK("hold", 16'hbeef, hold_image[80+:16])
        run(6, 128'h110300050001, 5, 128'h110302beef, 1);
        run(6, 128'h1104000e0002, 7, 128'h110404100e100f, 0);
    endtask : t_regs
    task automatic t_multi();
        run(9, 128'h110f0000000a02cd01, 6, 128'h110f0000000a, 0);
        `CHK("coils", 10'h1cd, coil_out[9:0])
        run(11, 128'h1110000200020412345678, 6, 128'h111000020002, 0);
        `CHK("hold", 32'h56781234, hold_image[32+:32])
    endtask : t_multi
    task automatic t_misc();
        run(12, 128'h11080102030405060708090a, 12, 128'h11080102030405060708090a, 1);
        run(6, 128'h120300000001, 0, 128'h0, 0);
        run(6, 128'h110700000001, 3, 128'h118701, 0);
    endtask : t_misc
    task automatic complete_run();
        error_cnt += host.hung;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : complete_run
    initial begin
        for (int i = 0; i < 16; i++) in_regs[i*16+:16] = 16'h1000 + 16'(i);
        repeat (10) @(posedge sys_clk);
        #1 reset = 1'b0;
        `CHK("hold_rst", 256'h0, hold_image)
        t_bits();
        t_coil();
        t_regs();
        t_multi();
        t_misc();
        complete_run();
    end
endmodule : tb_modbus_function_responder
`default_nettype wire
